//--- charger_supervision.sv
// Charger supervision register, status registers, timer and indicator
`timescale 1ns/1ps
`include "charger_regs.svh"
module charger_supervision (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic ADAPTER_PRESENT,
  input wire logic CHARGE_ENABLE,
  input wire logic CHARGING,
  input wire logic CONST_CURRENT_PHASE,
  input wire logic TRICKLE_PHASE,
  input wire logic CONST_VOLTAGE_PHASE,
  input wire logic BATTERY_RESUME,
  input wire logic CHARGE_DONE,
  input wire logic TEMP_HIGH,
  input wire logic THERM_OPEN,
  input wire logic THERM_SUPERVISION_EN,
  input wire logic BATTERY_LOW,
  input wire logic BATTERY_OVERVOLTAGE,
  input wire logic INPUT_LOW,
  input wire logic INPUT_OVERVOLTAGE,
  input wire logic INPUT_UNDERVOLTAGE_LOCKOUT,
  input wire logic BOOST_ACTIVE,
  input wire logic BOOST_OVERCURRENT_DEB,
  input wire logic BATTERY_BELOW_BOOST_MIN,
  input wire logic CURRENT_LIMIT_ACTIVE,
  input wire logic DIE_OVERHEAT,
  output logic CHARGE_STOP,
  output logic STATUS_PIN
);
  import charger_pkg::*;

  typedef struct packed {
    logic [3:0] limit;
    logic tmax;
    ind_mode_e mode;
    logic [43:0] timer;
    logic terminated;
    logic [7:0] rdata;
    logic stop;
    logic pin;
  } sup_s;
  sup_s st_r;
  sup_s st_nxt;

  blink_if bl ();
  blink_gen u_blink (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .bl(bl)
  );

  // Limit in cycles: code times a half hour
  function automatic logic [43:0] limit_cycles(input logic [3:0] code);
    limit_cycles = 44'(64'(code) * `HALF_HOUR_CYC);
  endfunction

  logic hot;
  logic absent;
  logic halt;
  logic boost_fault;
  logic [7:0] status1;
  logic [7:0] status2;
  logic [7:0] supervision;
  logic sup_wr;
  logic expire;

  // Live status views; comparator levels pass through ungated except hot (gated by adapter) and absent (gated by supervision enable)
  always_comb begin
    hot = TEMP_HIGH & ADAPTER_PRESENT;
    absent = THERM_OPEN & THERM_SUPERVISION_EN;
    boost_fault = BOOST_OVERCURRENT_DEB | BATTERY_BELOW_BOOST_MIN |
                  INPUT_OVERVOLTAGE | CURRENT_LIMIT_ACTIVE;
    halt = st_r.tmax | (TEMP_HIGH & THERM_SUPERVISION_EN) |
           INPUT_OVERVOLTAGE | BATTERY_OVERVOLTAGE |
           INPUT_UNDERVOLTAGE_LOCKOUT | DIE_OVERHEAT;
    status1 = {absent, hot, st_r.terminated, CONST_VOLTAGE_PHASE,
               TRICKLE_PHASE, BATTERY_RESUME, CONST_CURRENT_PHASE,
               ADAPTER_PRESENT};
    status2 = {halt, boost_fault, BOOST_ACTIVE, INPUT_UNDERVOLTAGE_LOCKOUT,
               INPUT_OVERVOLTAGE, INPUT_LOW, BATTERY_OVERVOLTAGE,
               BATTERY_LOW};
    supervision = {st_r.mode, st_r.tmax, st_r.limit};
    sup_wr = REG_WR & (REG_ADDR == `ADDR_SUPERVISION);
    // Expiry: the count has reached code times a half hour less one, in the last charging cycle of the limit
    expire = st_r.limit != 4'h0 && CHARGING && !st_r.tmax &&
             st_r.timer >= limit_cycles(st_r.limit) - 44'h1;
  end

  // Next state: register writes, timer, termination flag, stop, read data, pin
  always_comb begin
    st_nxt = st_r;
    // Status addresses ignore writes, keeping them read-only
    if (sup_wr) begin
      st_nxt.limit = REG_WDATA[`LIMIT_MSB:`LIMIT_LSB];
      st_nxt.mode = ind_mode_e'(REG_WDATA[`MODE_MSB:`MODE_LSB]);
    end
    // Timer: write of 0 to the hit bit restarts it and clears the hit
    if (sup_wr && !REG_WDATA[`TMAX_BIT]) begin
      st_nxt.timer = '0;
      st_nxt.tmax = expire; // Expiry in the same cycle still wins
    end else if (expire) begin
      st_nxt.tmax = 1'b1;
    end else if (st_r.limit != 4'h0 && CHARGING && !st_r.tmax) begin
      st_nxt.timer = st_r.timer + 44'h1;
    end
    // Termination flag: set wins over the clears
    if (CHARGE_DONE) begin
      st_nxt.terminated = 1'b1;
    end else if (!CHARGE_ENABLE || BATTERY_RESUME) begin
      st_nxt.terminated = 1'b0;
    end
    st_nxt.stop = halt;
    // Read data registered one cycle after the strobe
    if (REG_RD) begin
      case (REG_ADDR)
        `ADDR_SUPERVISION: st_nxt.rdata = supervision;
        `ADDR_STATUS1: st_nxt.rdata = status1;
        `ADDR_STATUS2: st_nxt.rdata = status2;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.pin = bl.pin_on;
  end

  // Pattern choice: fault blink beats termination blink beats steady on
  always_comb begin
    bl.pattern = PAT_OFF;
    case (st_r.mode)
      IND_OFF: bl.pattern = PAT_OFF;
      IND_ADAPTER: bl.pattern = ADAPTER_PRESENT ? PAT_ON : PAT_OFF;
      IND_ADAPTER_FAST: begin
        if (halt || boost_fault) bl.pattern = PAT_FAST;
        else if (ADAPTER_PRESENT) bl.pattern = PAT_ON;
      end
      IND_CHARGE_FAST: begin
        if (halt || boost_fault) bl.pattern = PAT_FAST;
        else if (CHARGING) bl.pattern = PAT_ON;
      end
      IND_CHARGE_SLOW: begin
        if (halt || boost_fault) bl.pattern = PAT_FAST;
        else if (st_r.terminated) bl.pattern = PAT_SLOW;
        else if (CHARGING) bl.pattern = PAT_ON;
      end
      IND_ADAPTER_SLOW: begin
        if (halt || boost_fault) bl.pattern = PAT_FAST;
        else if (st_r.terminated) bl.pattern = PAT_SLOW;
        else if (ADAPTER_PRESENT) bl.pattern = PAT_ON;
      end
      default: bl.pattern = PAT_OFF;
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= '0;
      st_r.limit <= 4'(`SUPERVISION_RESET >> `LIMIT_LSB);
      st_r.mode <= ind_mode_e'(3'(`SUPERVISION_RESET >> `MODE_LSB));
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = st_r.rdata;
  assign CHARGE_STOP = st_r.stop;
  assign STATUS_PIN = st_r.pin;

  // A 0 written to the hit bit restarts the counter; expiry still wins
  limit_clear_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    sup_wr && !REG_WDATA[`TMAX_BIT] |=>
    st_r.timer == '0 && st_r.tmax == $past(expire))
    else $error("timer not restarted by write");
  // Reaching the limit raises the sticky hit bit
  expiry_set_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    expire |=>
    st_r.tmax)
    else $error("hit bit not set at expiry");
  // The hit bit only falls on a 0 write
  tmax_hold_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    st_r.tmax && !(sup_wr && !REG_WDATA[`TMAX_BIT]) |=>
    st_r.tmax)
    else $error("hit bit lost without a clear");
  // Counter idles while not charging
  timer_hold_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    !CHARGING && !sup_wr |=>
    $stable(st_r.timer))
    else $error("timer moved while not charging");
  // Counter steps once per charging cycle below the limit
  timer_step_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    st_r.limit != 4'h0 && CHARGING && !st_r.tmax && !expire && !sup_wr |=>
    st_r.timer == $past(st_r.timer) + 44'h1)
    else $error("timer did not advance while charging");
  // Code 0 keeps the counter still
  timer_off_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    st_r.limit == 4'h0 && !sup_wr |=>
    $stable(st_r.timer))
    else $error("timer moved while disabled");
  // Writes load the limit field
  limit_write_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    sup_wr |=>
    st_r.limit == $past(REG_WDATA[`LIMIT_MSB:`LIMIT_LSB]))
    else $error("limit field not loaded");
  // Writes load the indicator mode field
  mode_write_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    sup_wr |=>
    st_r.mode == $past(REG_WDATA[`MODE_MSB:`MODE_LSB]))
    else $error("mode field not loaded");
  // Input overvoltage, die overheat or a timer hit stops charging one cycle later
  halt_stop_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    (INPUT_OVERVOLTAGE || DIE_OVERHEAT || st_r.tmax) |=>
    CHARGE_STOP)
    else $error("charge not stopped on fault");
  // With no halt cause the stop output falls
  stop_clear_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    !halt |=>
    !CHARGE_STOP)
    else $error("charge stopped with no cause");
  // End of charge sets the termination flag
  term_set_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    CHARGE_DONE |=>
    st_r.terminated)
    else $error("termination flag not set");
  // Enable off clears the termination flag
  term_clear_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    !CHARGE_DONE && !CHARGE_ENABLE |=>
    !st_r.terminated)
    else $error("termination flag not cleared");
  // Resume clears the termination flag
  term_resume_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    !CHARGE_DONE && BATTERY_RESUME |=>
    !st_r.terminated)
    else $error("termination flag kept on resume");
  // Supervision read returns the live fields
  sup_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    REG_RD && REG_ADDR == `ADDR_SUPERVISION |=>
    REG_RDATA == $past(supervision))
    else $error("supervision read mismatch");
  // First status read returns the live view
  status_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    REG_RD && REG_ADDR == `ADDR_STATUS1 |=>
    REG_RDATA == $past(status1))
    else $error("status read mismatch");
  // Second status read returns the live view
  status2_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    REG_RD && REG_ADDR == `ADDR_STATUS2 |=>
    REG_RDATA == $past(status2))
    else $error("second status read mismatch");
  // Read data stands until the next read
  rdata_hold_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    !REG_RD |=>
    $stable(REG_RDATA))
    else $error("read data changed without a read");
  // Pin lags the pattern by two registers
  mode_off_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    st_r.mode == IND_OFF |->
    ##2 !STATUS_PIN)
    else $error("pin lit in off mode");
  // Steady pattern lights the pin two cycles on
  pin_on_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    bl.pattern == PAT_ON |->
    ##2 STATUS_PIN)
    else $error("pin dark in steady pattern");
  // Fault blink outranks the termination blink
  fault_blink_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    st_r.mode == IND_CHARGE_SLOW && halt |->
    bl.pattern == PAT_FAST)
    else $error("fault blink lost priority");
endmodule // charger_supervision

//--- charger_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH
`define ADDR_SUPERVISION 8'h04
`define ADDR_STATUS1 8'h05
`define ADDR_STATUS2 8'h06
`define SUPERVISION_RESET 8'h4A
`define LIMIT_LSB 0
`define LIMIT_MSB 3
`define TMAX_BIT 4
`define MODE_LSB 5
`define MODE_MSB 7
`define CLK_HZ 200000000
`define HALF_HOUR_S 1800
`define FAST_BLINK_HZ 5
`define SLOW_BLINK_HZ 1
`define FAST_HALF_CYC (`CLK_HZ / (2 * `FAST_BLINK_HZ))
`define SLOW_HALF_CYC (`CLK_HZ / (2 * `SLOW_BLINK_HZ))
`define HALF_HOUR_CYC (64'(`CLK_HZ) * 64'(`HALF_HOUR_S))
`endif

//--- charger_pkg.sv
// Types shared by the supervision block
package charger_pkg;
  typedef enum logic [2:0] {
    IND_OFF, IND_ADAPTER, IND_ADAPTER_FAST, IND_CHARGE_FAST,
    IND_CHARGE_SLOW, IND_ADAPTER_SLOW, IND_RSV6, IND_RSV7
  } ind_mode_e;
  typedef enum logic [1:0] {PAT_OFF, PAT_ON, PAT_SLOW, PAT_FAST} pattern_e;
endpackage

//--- blink_if.sv
// Pattern request and pin level between supervisor and blinker
`timescale 1ns/1ps
interface blink_if;
  charger_pkg::pattern_e pattern;
  logic pin_on;
  modport ctrl (output pattern, input pin_on);
  modport gen (input pattern, output pin_on);
endinterface

//--- blink_gen.sv
// Steady and blinking pattern generator for the indicator pin
`timescale 1ns/1ps
`include "charger_regs.svh"
module blink_gen (
  input wire logic clk,
  input wire logic rst,
  blink_if.gen bl
);
  import charger_pkg::*;
  typedef struct packed {
    logic [27:0] fast_cnt;
    logic [27:0] slow_cnt;
    logic fast_ph;
    logic slow_ph;
    logic pin;
  } blink_s;
  blink_s st_r;
  blink_s st_nxt;

  // Free-running phases so a pattern change never waits for a restart
  always_comb begin
    st_nxt = st_r;
    if (st_r.fast_cnt == 28'(`FAST_HALF_CYC - 1)) begin
      st_nxt.fast_cnt = '0;
      st_nxt.fast_ph = ~st_r.fast_ph;
    end else begin
      st_nxt.fast_cnt = st_r.fast_cnt + 28'h1;
    end
    if (st_r.slow_cnt == 28'(`SLOW_HALF_CYC - 1)) begin
      st_nxt.slow_cnt = '0;
      st_nxt.slow_ph = ~st_r.slow_ph;
    end else begin
      st_nxt.slow_cnt = st_r.slow_cnt + 28'h1;
    end
    case (bl.pattern)
      PAT_ON: st_nxt.pin = 1'b1;
      PAT_SLOW: st_nxt.pin = st_r.slow_ph;
      PAT_FAST: st_nxt.pin = st_r.fast_ph;
      default: st_nxt.pin = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bl.pin_on = st_r.pin;

  fast_period_a: assert property (@(posedge clk) disable iff (rst)
    st_r.fast_cnt == 28'(`FAST_HALF_CYC - 1) |=> $changed(st_r.fast_ph))
    else $error("fast blink phase did not toggle");
endmodule // blink_gen

//--- host_model.sv
// Host controller model speaking the register strobe port
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // Idle port until the first request
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // One strobe cycle; data is scrambled after release so stale data never
  // passes for a fresh write
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~v;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask
endmodule // host_model

//--- tb_top.sv
// Self-checking bench for the charger supervision block
`timescale 1ns/1ps
`include "charger_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  mismatches++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end end
module tb_top;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [20:0] st;
  logic stop;
  logic pin;
  logic [7:0] d;
  logic [7:0] s2_exp [8:17];
  int mismatches = 0;
  int checked = 0;
  // Status inputs are packed in one vector, status1 order first
  charger_supervision dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .ADAPTER_PRESENT(st[0]), .CONST_CURRENT_PHASE(st[1]),
    .BATTERY_RESUME(st[2]), .TRICKLE_PHASE(st[3]),
    .CONST_VOLTAGE_PHASE(st[4]), .CHARGE_DONE(st[5]), .TEMP_HIGH(st[6]),
    .THERM_OPEN(st[7]), .BATTERY_LOW(st[8]), .BATTERY_OVERVOLTAGE(st[9]),
    .INPUT_LOW(st[10]), .INPUT_OVERVOLTAGE(st[11]),
    .INPUT_UNDERVOLTAGE_LOCKOUT(st[12]), .BOOST_ACTIVE(st[13]),
    .BOOST_OVERCURRENT_DEB(st[14]), .BATTERY_BELOW_BOOST_MIN(st[15]),
    .CURRENT_LIMIT_ACTIVE(st[16]), .DIE_OVERHEAT(st[17]),
    .CHARGE_ENABLE(st[18]), .CHARGING(st[19]),
    .THERM_SUPERVISION_EN(st[20]), .CHARGE_STOP(stop), .STATUS_PIN(pin));
  host_model host (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops the run
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Tests take under two hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    s2_exp = '{8'h01, 8'h82, 8'h04, 8'hC8, 8'h90,
               8'h20, 8'h40, 8'h40, 8'h40, 8'h80};
    st = '0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    host.read_reg(`ADDR_SUPERVISION, d);
    `CHK("sup_reset", `SUPERVISION_RESET, d)
    host.write_reg(`ADDR_SUPERVISION, 8'hB7);
    host.read_reg(`ADDR_SUPERVISION, d);
    `CHK("sup_hit_w1", 8'hA7, d)
    host.write_reg(`ADDR_SUPERVISION, 8'hE3);
    host.read_reg(`ADDR_SUPERVISION, d);
    `CHK("sup_w0", 8'hE3, d)
    host.write_reg(`ADDR_STATUS1, 8'hFF);
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("status1_ro", 8'h00, d)
    host.read_reg(`ADDR_SUPERVISION, d);
    `CHK("sup_kept", 8'hE3, d)
    host.read_reg(8'h07, d);
    `CHK("unmapped", 8'h00, d)
    $display("test registers done");
    // One live flag at a time must land on its own bit
    for (int i = 0; i < 5; i++) begin
      st = 21'(1) << i;
      host.read_reg(`ADDR_STATUS1, d);
      `CHK("status1", 8'(1) << i, d)
    end
    st = 21'h000040;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("hot_no_adapter", 8'h00, d)
    st = 21'h000041;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("hot", 8'h41, d)
    st = 21'h000080;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("absent_off", 8'h00, d)
    st = 21'h100080;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("absent", 8'h80, d)
    // Termination flag holds after the event and drops with enable
    st = 21'h040020;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("term_set", 8'h20, d)
    st = 21'h040000;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("term_hold", 8'h20, d)
    st = '0;
    host.read_reg(`ADDR_STATUS1, d);
    `CHK("term_clear", 8'h00, d)
    $display("test status1 done");
    // Each supply cause alone, with its fault and halt consequences
    for (int i = 8; i < 18; i++) begin
      st = 21'(1) << i;
      host.read_reg(`ADDR_STATUS2, d);
      `CHK("status2", s2_exp[i], d)
      `CHK("stop", s2_exp[i][7], stop)
    end
    st = 21'h100040;
    host.read_reg(`ADDR_STATUS2, d);
    `CHK("temp_halt", 8'h80, d)
    $display("test status2 done");
    // Steady pin level in every mode with adapter and charging, no fault
    st = 21'h0C0001;
    for (int m = 0; m < 8; m++) begin
      host.write_reg(`ADDR_SUPERVISION, {3'(m), 5'h03});
      repeat (4) @(negedge clk);
      `CHK("pin", 1'(m > 0 && m < 6), pin)
    end
    host.write_reg(`ADDR_SUPERVISION, 8'h23);
    st = 21'h0C0000;
    repeat (4) @(negedge clk);
    `CHK("pin_no_adapter", 1'b0, pin)
    // Termination and fault blink priority seen at the pattern request
    st = 21'h0C0021;
    host.write_reg(`ADDR_SUPERVISION, 8'h83);
    repeat (2) @(negedge clk);
    `CHK("slow_blink", charger_pkg::PAT_SLOW, dut.bl.pattern)
    st = 21'h0C0821;
    repeat (2) @(negedge clk);
    `CHK("fault_first", charger_pkg::PAT_FAST, dut.bl.pattern)
    st = 21'h0C0001;
    host.write_reg(`ADDR_SUPERVISION, 8'hA3);
    repeat (2) @(negedge clk);
    `CHK("slow_adapter", charger_pkg::PAT_SLOW, dut.bl.pattern)
    st = 21'h080001;
    repeat (2) @(negedge clk);
    `CHK("term_dropped", charger_pkg::PAT_ON, dut.bl.pattern)
    $display("test indicator done");
    // Time-limit counter: counts charging cycles, code 0 stops it
    st = 21'h0C0000;
    host.write_reg(`ADDR_SUPERVISION, 8'h03);
    repeat (10) @(negedge clk);
    `CHK("timer_count", 44'hA, dut.st_r.timer)
    st = 21'h040000;
    repeat (5) @(negedge clk);
    `CHK("timer_idle", 44'hA, dut.st_r.timer)
    host.write_reg(`ADDR_SUPERVISION, 8'h13);
    `CHK("timer_w1", 44'hA, dut.st_r.timer)
    host.write_reg(`ADDR_SUPERVISION, 8'h00);
    `CHK("timer_w0", 44'h0, dut.st_r.timer)
    st = 21'h0C0000;
    repeat (5) @(negedge clk);
    `CHK("timer_off", 44'h0, dut.st_r.timer)
    $display("test timer done");
    end_sim();
  end
endmodule // tb_top
